// File: rtl/rx_opt_defines.svh
`ifndef RX_OPT_DEFINES_SVH
`define RX_OPT_DEFINES_SVH

// geometry
`define NUM_PORTS 4
`define PORT_W 2
`define STAT_W 2
`define FILL_W 9
`define PB_CNT_W 9
`define PB_THR_W 8
`define PB_DEPTH 9'h100
`define PKT_CNT_W 8
// build configuration
`define DPATH_WIDTH 64
`define MCONT_ENABLE 1
`define BUF_SHARED 1
// status channel codes beyond the enum
`define STAT_FRAMING 2'h3
`define STATUS_RST 2'h3
// performance setting and memory bank masks
`define PERF_SINGLE 2'h0
`define PERF_DUAL 2'h1
`define PERF_QUAD 2'h2
`define MEM_ONE 4'h1
`define MEM_TWO 4'h3
`define MEM_FOUR 4'hf
`endif

// File: rtl/rx_opt_pkg.sv
package rx_opt_pkg;
  // per-port status values sent on the status channel
  typedef enum logic [1:0] {stat_starving, stat_hungry, stat_satisfied} fifo_stat_e;
  // pre-buffer protection state
  typedef enum logic [1:0] {pb_normal, pb_backpressure, pb_overflow} pb_state_e;
endpackage : rx_opt_pkg

// File: rtl/prebuf_if.sv
`timescale 1ns/10ps
`include "rx_opt_defines.svh"
interface prebuf_if;
  logic push;
  logic pop;
  logic [`PB_THR_W-1:0] threshold;
  logic backpressure;
  logic overflow;
  logic [`PB_CNT_W-1:0] level;
  modport tracker (input push, input pop, input threshold,
                   output backpressure, output overflow, output level);
  modport user (output push, output pop, output threshold,
                input backpressure, input overflow, input level);
endinterface : prebuf_if

// File: rtl/prebuf_tracker.sv
`timescale 1ns/10ps
`include "rx_opt_defines.svh"
module prebuf_tracker (
  input wire logic sys_clk,
  input wire logic resetn,
  prebuf_if.tracker pb
);
  rx_opt_pkg::pb_state_e state;
  rx_opt_pkg::pb_state_e next_state;
  logic [`PB_CNT_W-1:0] level;
  logic full;
  logic empty;
  logic lost;

  assign full = (level == `PB_DEPTH);
  assign empty = (level == {`PB_CNT_W{1'b0}});
  // a push into a full pre-buffer with no pop drops the word
  assign lost = pb.push && !pb.pop && full;

  // occupancy of the 256-entry pre-buffer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level <= {`PB_CNT_W{1'b0}};
    end else if (pb.push && !pb.pop && !full) begin
      level <= level + 9'h001;
    end else if (pb.pop && !pb.push && !empty) begin
      level <= level - 9'h001;
    end
  end

  // overflow outranks backpressure; both end only on a drained buffer
  always_comb begin
    next_state = state;
    case (state)
      rx_opt_pkg::pb_normal: begin
        if (lost) begin
          next_state = rx_opt_pkg::pb_overflow;
        end else if (level > {1'b0, pb.threshold}) begin
          next_state = rx_opt_pkg::pb_backpressure;
        end
      end
      rx_opt_pkg::pb_backpressure: begin
        if (lost) begin
          next_state = rx_opt_pkg::pb_overflow;
        end else if (empty) begin
          next_state = rx_opt_pkg::pb_normal;
        end
      end
      rx_opt_pkg::pb_overflow: begin
        if (empty && !lost) begin
          next_state = rx_opt_pkg::pb_normal;
        end
      end
      default: begin
        next_state = rx_opt_pkg::pb_normal;
      end
    endcase
  end

  // protection state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= rx_opt_pkg::pb_normal;
    end else begin
      state <= next_state;
    end
  end

  assign pb.backpressure = (state == rx_opt_pkg::pb_backpressure);
  assign pb.overflow = (state == rx_opt_pkg::pb_overflow);
  assign pb.level = level;
endmodule : prebuf_tracker

// File: rtl/rx_status_options.sv
`timescale 1ns/10ps
`include "rx_opt_defines.svh"
module rx_status_options (
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic use_override,
  input wire logic [`NUM_PORTS*`STAT_W-1:0] override_status,
  input wire logic [`FILL_W-1:0] shared_fill,
  input wire logic [`FILL_W-1:0] almost_full_threshold,
  input wire logic [`FILL_W-1:0] almost_empty_threshold,
  input wire logic [`FILL_W-1:0] fill_threshold_level,
  input wire logic eop_dav_enable,
  input wire logic [`PB_THR_W-1:0] pre_buffer_threshold,
  input wire logic pb_push,
  input wire logic pb_pop,
  input wire logic [1:0] perf_setting,
  input wire logic check_enable,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic [`PORT_W-1:0] rx_port,
  input wire logic app_eop_read,
  output logic [`NUM_PORTS*`STAT_W-1:0] port_status,
  output logic status_framing,
  output logic pre_buffer_overflow,
  output logic [`PB_CNT_W-1:0] pre_buffer_level,
  output logic [3:0] mem_bank_enable,
  output logic wr_valid,
  output logic wr_sop,
  output logic wr_eop,
  output logic [`PORT_W-1:0] wr_port,
  output logic wr_err,
  output logic msop_err,
  output logic meop_err,
  output logic app_data_avail
);

  ////////////////////////////////////////////////////////////////////
  // build-time configuration

  // the pre-buffer only exists where incoming words may need more
  // than one reference cycle to process
  localparam bit pb_present = (`DPATH_WIDTH == 64) ||
                              ((`DPATH_WIDTH == 128) && (`MCONT_ENABLE == 1));
  localparam logic [1:0] perf_default = (`DPATH_WIDTH == 64) ?
                                        `PERF_QUAD : `PERF_SINGLE;
  localparam bit override_built = (`BUF_SHARED == 1);

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // one status value for the whole shared buffer
  function automatic logic [`STAT_W-1:0] fill_status(
    input logic [`FILL_W-1:0] fill,
    input logic [`FILL_W-1:0] ae,
    input logic [`FILL_W-1:0] af
  );
    logic [`STAT_W-1:0] code;
    if (fill > af) begin
      code = rx_opt_pkg::stat_satisfied;
    end else if (fill < ae) begin
      code = rx_opt_pkg::stat_starving;
    end else begin
      code = rx_opt_pkg::stat_hungry;
    end
    return code;
  endfunction : fill_status

  // code 11 is meaningless here; treat it as satisfied so a bad
  // application value throttles rather than floods
  function automatic logic [`STAT_W-1:0] override_code(
    input logic [`STAT_W-1:0] raw
  );
    logic [`STAT_W-1:0] code;
    code = raw;
    if (raw == `STAT_FRAMING) begin
      code = rx_opt_pkg::stat_satisfied;
    end
    return code;
  endfunction : override_code

  ////////////////////////////////////////////////////////////////////
  // pre-buffer protection

  prebuf_if pb_bus ();

  assign pb_bus.push = pb_push;
  assign pb_bus.pop = pb_pop;
  assign pb_bus.threshold = pre_buffer_threshold;

  generate
    if (pb_present) begin : g_prebuf
      prebuf_tracker u_prebuf (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pb(pb_bus.tracker)
      );
    end else begin : g_no_prebuf
      assign pb_bus.backpressure = 1'b0;
      assign pb_bus.overflow = 1'b0;
      assign pb_bus.level = {`PB_CNT_W{1'b0}};
    end
  endgenerate

  assign pre_buffer_overflow = pb_bus.overflow;
  assign pre_buffer_level = pb_bus.level;

  ////////////////////////////////////////////////////////////////////
  // status channel generation

  logic override_active;
  logic [`STAT_W-1:0] shared_code;

  // the select is expected static outside reset, so no hold logic
  assign override_active = override_built && use_override;
  assign shared_code = fill_status(shared_fill, almost_empty_threshold,
                                   almost_full_threshold);

  generate
    for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port_stat
      logic [`STAT_W-1:0] next_code;
      logic [`STAT_W-1:0] ovr_sample;

      // override bits are looked at only while selected
      assign ovr_sample = override_active ?
                          override_code(override_status[p*`STAT_W +: `STAT_W]) :
                          shared_code;

      // framing beats backpressure beats normal status
      always_comb begin
        next_code = shared_code;
        if (pb_bus.overflow) begin
          next_code = `STAT_FRAMING;
        end else if (pb_bus.backpressure) begin
          next_code = rx_opt_pkg::stat_satisfied;
        end else if (override_active) begin
          next_code = ovr_sample;
        end
      end

      // registered so the status channel never sees decode glitches
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          port_status[p*`STAT_W +: `STAT_W] <= `STATUS_RST;
        end else begin
          port_status[p*`STAT_W +: `STAT_W] <= next_code;
        end
      end
    end
  endgenerate

  // framing flag accompanies the 11 code on every port
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_framing <= 1'b1;
    end else begin
      status_framing <= pb_bus.overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // memory structure selection

  // unsupported 11 falls back to the data-path default
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_bank_enable <= `MEM_ONE;
    end else begin
      case ((perf_setting == 2'h3) ? perf_default : perf_setting)
        `PERF_SINGLE: begin
          mem_bank_enable <= `MEM_ONE;
        end
        `PERF_DUAL: begin
          mem_bank_enable <= `MEM_TWO;
        end
        `PERF_QUAD: begin
          mem_bank_enable <= `MEM_FOUR;
        end
        default: begin
          mem_bank_enable <= `MEM_ONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // missing start / end of packet checking

  logic [`NUM_PORTS-1:0] in_pkt;
  logic [`NUM_PORTS-1:0] pend_err;
  logic beat_msop;
  logic beat_meop;
  logic beat_err;

  // with checking off nothing is flagged and packets merge
  assign beat_msop = check_enable && rx_valid && !rx_sop && !in_pkt[rx_port];
  assign beat_meop = check_enable && rx_valid && rx_sop && in_pkt[rx_port];
  assign beat_err = beat_msop || beat_meop;

  generate
    for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port_chk
      // packet-open tracking per port
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          in_pkt[p] <= 1'b0;
        end else if (!check_enable) begin
          in_pkt[p] <= 1'b0;
        end else if (rx_valid && (rx_port == p)) begin
          in_pkt[p] <= !rx_eop;
        end
      end

      // error held until the port's next end of packet carries it
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pend_err[p] <= 1'b0;
        end else if (!check_enable) begin
          pend_err[p] <= 1'b0;
        end else if (rx_valid && (rx_port == p)) begin
          if (rx_eop) begin
            pend_err[p] <= 1'b0;
          end else if (beat_err) begin
            pend_err[p] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // buffer write stream and error pulses, one cycle after the beat
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_valid <= 1'b0;
      wr_sop <= 1'b0;
      wr_eop <= 1'b0;
      wr_port <= {`PORT_W{1'b0}};
      wr_err <= 1'b0;
    end else begin
      wr_valid <= rx_valid;
      wr_sop <= rx_valid && rx_sop;
      wr_eop <= rx_valid && rx_eop;
      wr_port <= rx_port;
      wr_err <= rx_valid && rx_eop && (pend_err[rx_port] || beat_err);
    end
  end

  // missing-marker flags
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      msop_err <= 1'b0;
      meop_err <= 1'b0;
    end else begin
      msop_err <= beat_msop;
      meop_err <= beat_meop;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link clock domain reset

  logic link_rst_meta;
  logic link_rstn;

  // asynchronous assert, release aligned to the link clock
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_rst_meta <= 1'b0;
      link_rstn <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_rstn <= link_rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // packet-read events from the application, link to sys by toggle

  logic read_tog;
  logic read_meta;
  logic read_sync;
  logic read_seen;
  logic read_event;

  // one toggle per packet end taken by the application
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      read_tog <= 1'b0;
    end else if (app_eop_read) begin
      read_tog <= !read_tog;
    end
  end

  // reads closer than about two sys cycles apart merge; the link
  // clock is slower, so that cannot happen here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      read_meta <= 1'b0;
      read_sync <= 1'b0;
      read_seen <= 1'b0;
    end else begin
      read_meta <= read_tog;
      read_sync <= read_meta;
      read_seen <= read_sync;
    end
  end

  assign read_event = read_sync ^ read_seen;

  ////////////////////////////////////////////////////////////////////
  // data available

  logic [`PKT_CNT_W-1:0] pkt_count;
  logic pkt_in;
  logic dav_level;
  logic dav_meta;
  logic dav_sync;

  assign pkt_in = wr_valid && wr_eop;

  // whole packets stored; a push and a read together cancel out
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pkt_count <= {`PKT_CNT_W{1'b0}};
    end else if (pkt_in && !read_event && (pkt_count != {`PKT_CNT_W{1'b1}})) begin
      pkt_count <= pkt_count + 8'h01;
    end else if (read_event && !pkt_in && (pkt_count != {`PKT_CNT_W{1'b0}})) begin
      pkt_count <= pkt_count - 8'h01;
    end
  end

  // level computed in the reference domain, crossed as a level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dav_level <= 1'b0;
    end else begin
      dav_level <= (shared_fill > fill_threshold_level) ||
                   (eop_dav_enable && (pkt_count != {`PKT_CNT_W{1'b0}}));
    end
  end

  // two-flop synchroniser into the application clock
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      dav_meta <= 1'b0;
      dav_sync <= 1'b0;
    end else begin
      dav_meta <= dav_level;
      dav_sync <= dav_meta;
    end
  end

  assign app_data_avail = dav_sync;
endmodule : rx_status_options

// File: bench/rx_status_options_monitor.sv
`timescale 1ns/10ps
`include "rx_opt_defines.svh"
module rx_status_options_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic use_override,
  input wire logic [`NUM_PORTS*`STAT_W-1:0] override_status,
  input wire logic [`FILL_W-1:0] shared_fill,
  input wire logic [`FILL_W-1:0] almost_full_threshold,
  input wire logic [`FILL_W-1:0] almost_empty_threshold,
  input wire logic [`PB_THR_W-1:0] pre_buffer_threshold,
  input wire logic [1:0] perf_setting,
  input wire logic check_enable,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic [`NUM_PORTS*`STAT_W-1:0] port_status,
  input wire logic status_framing,
  input wire logic pre_buffer_overflow,
  input wire logic [`PB_CNT_W-1:0] pre_buffer_level,
  input wire logic [3:0] mem_bank_enable,
  input wire logic wr_eop,
  input wire logic wr_err,
  input wire logic msop_err,
  input wire logic meop_err
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [2:0] quiet;
  // idle pre-buffer cycles; status lags the pre-buffer level by two edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) quiet <= 3'h0;
    else if (pre_buffer_level != 9'h0 || pre_buffer_overflow) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  framing_all_a: assert property (status_framing |-> port_status == 8'hff)
    else $error("framing flag without all-ones status");
  override_pass_a: assert property (quiet > 3'h3 && $past(use_override) |->
    port_status == $past(override_status)) else $error("override status not sent");
  shared_full_a: assert property (quiet > 3'h3 && !$past(use_override) &&
    $past(shared_fill) > $past(almost_full_threshold) |-> port_status == 8'haa)
    else $error("full shared buffer not satisfied");
  shared_empty_a: assert property (quiet > 3'h3 && !$past(use_override) &&
    $past(shared_fill) < $past(almost_empty_threshold) |-> port_status == 8'h00)
    else $error("empty shared buffer not starving");
  backpressure_a: assert property (pre_buffer_level > {1'b0, pre_buffer_threshold} |->
    ##[1:3] (port_status == 8'haa || status_framing)) else $error("no backpressure");
  overflow_hold_a: assert property (pre_buffer_overflow && pre_buffer_level != 9'h0
    |=> pre_buffer_overflow) else $error("overflow dropped before empty");
  overflow_cause_a: assert property ($rose(pre_buffer_overflow) |->
    pre_buffer_level == `PB_DEPTH) else $error("overflow below full level");
  overflow_frame_a: assert property (pre_buffer_overflow |-> ##[0:2] status_framing)
    else $error("overflow without framing");
  bank_map_a: assert property ($past(resetn) |-> mem_bank_enable ==
    ($past(perf_setting) == 2'h0 ? 4'h1 : $past(perf_setting) == 2'h1 ? 4'h3 : 4'hf))
    else $error("memory structure mismatch");
  msop_cause_a: assert property (msop_err |-> $past(check_enable) && $past(rx_valid) &&
    !$past(rx_sop)) else $error("spurious missing start flag");
  meop_cause_a: assert property (meop_err |-> $past(check_enable && rx_valid && rx_sop))
    else $error("spurious missing end flag");
  err_on_eop_a: assert property (wr_err |-> wr_eop)
    else $error("packet error away from packet end");
endmodule : rx_status_options_monitor

bind rx_status_options rx_status_options_monitor mon_u (.*);

// File: bench/app_reader.sv
`timescale 1ns/10ps
module app_reader (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic want,
  output logic app_eop_read
);
  // one packet end per pulse; a free link cycle between reads keeps the crossing legal
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) app_eop_read <= 1'b0;
    else app_eop_read <= want && !app_eop_read;
  end
endmodule : app_reader

// File: bench/rx_status_options_tb.sv
`timescale 1ns/10ps
`include "rx_opt_defines.svh"
module rx_status_options_tb;
  logic [`NUM_PORTS*`STAT_W-1:0] override_status, port_status;
  logic [`FILL_W-1:0] shared_fill, almost_full_threshold, almost_empty_threshold;
  logic [`FILL_W-1:0] fill_threshold_level;
  logic [`PB_THR_W-1:0] pre_buffer_threshold;
  logic [`PB_CNT_W-1:0] pre_buffer_level;
  logic [1:0] perf_setting;
  logic [`PORT_W-1:0] rx_port;
  logic [3:0] mem_bank_enable;
  logic sys_clk, link_clk, resetn, use_override, eop_dav_enable, pb_push, pb_pop;
  logic check_enable, rx_valid, rx_sop, rx_eop, app_eop_read, want, wr_valid;
  logic status_framing, pre_buffer_overflow, wr_eop, wr_err, msop_err, meop_err;
  logic app_data_avail, seen_msop, seen_meop, last_err, wr_sop, seen_sop;
  logic [`PORT_W-1:0] wr_port, last_port;
  logic [3:0] banks [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
  logic [8:0] fills [5] = '{9'h0fa, 9'h0c8, 9'h064, 9'h032, 9'h00a};
  logic [7:0] stats [5] = '{8'haa, 8'h55, 8'h55, 8'h55, 8'h00};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  rx_status_options dut_u (.*);
  app_reader reader_u (.*);

  ////////////////////////////////////////////////////////////////////////////
  // clocks: link clock offset so the two never line up
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  // sticky copies so pulse timing does not matter to the checks, plus timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (msop_err === 1'b1) seen_msop <= 1'b1;
    if (meop_err === 1'b1) seen_meop <= 1'b1;
    if (wr_valid === 1'b1 && wr_sop === 1'b1) seen_sop <= 1'b1;
    if (wr_valid === 1'b1 && wr_eop === 1'b1) begin
      last_err <= wr_err;
      last_port <= wr_port;
    end
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // static settings may only move while reset is held
  task automatic do_reset(input logic ovr);
    resetn = 1'b0;
    use_override = ovr;
    tick(6);
    resetn = 1'b1;
    tick(6);
  endtask : do_reset
  task automatic pb(input logic push, input int n);
    pb_push = push;
    pb_pop = !push;
    tick(n);
    pb_push = 1'b0;
    pb_pop = 1'b0;
  endtask : pb
  task automatic beat(input logic s, input logic e, input logic [1:0] p);
    rx_valid = 1'b1;
    rx_sop = s;
    rx_eop = e;
    rx_port = p;
    tick(1);
    rx_valid = 1'b0;
    tick(1);
  endtask : beat
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    use_override = 1'b0;
    override_status = 8'h24;
    shared_fill = 9'h00a;
    almost_full_threshold = 9'h0c8;
    almost_empty_threshold = 9'h032;
    fill_threshold_level = 9'h064;
    eop_dav_enable = 1'b0;
    pre_buffer_threshold = 8'h02;
    pb_push = 1'b0;
    pb_pop = 1'b0;
    perf_setting = 2'h0;
    check_enable = 1'b1;
    rx_valid = 1'b0;
    rx_sop = 1'b0;
    rx_eop = 1'b0;
    rx_port = 2'h0;
    want = 1'b0;
    // every memory structure, setting moved just before each reset
    for (int i = 0; i < 4; i++) begin
      perf_setting = 2'(i);
      do_reset(1'b0);
      chk("mem_bank_enable", 9'(banks[i]), 9'(mem_bank_enable));
    end
    $display("test banks done");
    // shared status around both thresholds, equal values are not beyond them
    for (int i = 0; i < 5; i++) begin
      shared_fill = fills[i];
      tick(3);
      chk("shared status", 9'(stats[i]), 9'(port_status));
    end
    $display("test shared done");
    do_reset(1'b1);
    chk("override status", 9'h024, 9'(port_status));
    override_status = 8'h1a;
    tick(3);
    chk("override status", 9'h01a, 9'(port_status));
    do_reset(1'b0);
    chk("override ignored", 9'h000, 9'(port_status));
    $display("test override done");
    // threshold 2: three entries trip it, one left still holds it
    pb(1'b1, 3);
    tick(4);
    chk("backpressure", 9'h0aa, 9'(port_status));
    pb(1'b0, 2);
    tick(4);
    chk("backpressure held", 9'h0aa, 9'(port_status));
    pb(1'b0, 1);
    tick(5);
    chk("backpressure off", 9'h000, 9'(port_status));
    $display("test backpressure done");
    pb(1'b1, 257);
    tick(3);
    chk("overflow", 9'h001, 9'(pre_buffer_overflow));
    chk("framing", 9'h0ff, 9'(port_status));
    chk("pre level", 9'h100, pre_buffer_level);
    pb(1'b0, 255);
    tick(3);
    chk("framing held", 9'h001, 9'(status_framing));
    pb(1'b0, 1);
    tick(5);
    chk("overflow off", 9'h000, 9'(pre_buffer_overflow));
    chk("status back", 9'h000, 9'(port_status));
    $display("test overflow done");
    // same broken packets with checking on, then off
    for (int i = 1; i >= 0; i--) begin
      check_enable = i[0];
      seen_meop = 1'b0;
      seen_sop = 1'b0;
      beat(1'b1, 1'b0, 2'h1);
      beat(1'b1, 1'b0, 2'h1);
      beat(1'b0, 1'b1, 2'h1);
      tick(2);
      chk("meop_err", 9'(i), 9'(seen_meop));
      chk("eop error", 9'(i), 9'(last_err));
      chk("wr_sop", 9'h001, 9'(seen_sop));
      chk("eop port", 9'h001, 9'(last_port));
      seen_msop = 1'b0;
      seen_sop = 1'b0;
      beat(1'b0, 1'b0, 2'h2);
      beat(1'b0, 1'b1, 2'h2);
      tick(2);
      chk("msop_err", 9'(i), 9'(seen_msop));
      chk("eop error", 9'(i), 9'(last_err));
      chk("wr_sop", 9'h000, 9'(seen_sop));
      chk("eop port", 9'h002, 9'(last_port));
    end
    check_enable = 1'b1;
    $display("test check done");
    beat(1'b1, 1'b1, 2'h0);
    tick(12);
    chk("dav packet only", 9'h000, 9'(app_data_avail));
    shared_fill = 9'h0c8;
    tick(12);
    chk("dav above level", 9'h001, 9'(app_data_avail));
    shared_fill = 9'h00a;
    eop_dav_enable = 1'b1;
    do_reset(1'b0);
    beat(1'b1, 1'b1, 2'h0);
    tick(12);
    chk("dav on eop", 9'h001, 9'(app_data_avail));
    want = 1'b1;
    tick(12);
    want = 1'b0;
    tick(12);
    chk("dav after read", 9'h000, 9'(app_data_avail));
    $display("test dav done");
    end_of_test();
  end
endmodule : rx_status_options_tb
